// ### common/regulator_dropout_control_consts.svh
/*
 * Offsets, bit positions and reset values for the regulator dropout
 * control block.
 * Assumes a 32-bit APB word per register, each register at four times
 * its index, and data in the low byte.
 */
// Functional notes
// - Software picks one of two regulator output levels, 2.1 V or 2.6 V.
// - Regulator is enabled after any reset; software may disable it later.
// - Dropout interrupt request raised while dropout holds and enable is set.
// - Dropout request has no latched pending flag; follows live condition.
// - Dropout interrupt priority held in its own extended priority bit.
// - Dropout status bit 0 clears by hardware once dropout ends.
// - Bit 7 of regulator control disables regulator; resets to 0.
// - Bit 4 selects level, 0 is 2.1 V, 1 is 2.6 V; resets to 1.
// - Bit 0 read-only, reads 1 in or near dropout, else 0.
`ifndef REGULATOR_DROPOUT_CONTROL_CONSTS_SVH
`define REGULATOR_DROPOUT_CONTROL_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RDC_IDX_REG_CTRL 8'hC9
`define RDC_IDX_EXT_IRQ_EN2 8'hCA
`define RDC_IDX_EXT_IRQ_PRIO2 8'hCB
`define RDC_IDX_EVT_STATUS 8'hCC
`define RDC_IDX_EVT_MASK 8'hCD

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RDC_BIT_REG_OFF 7
`define RDC_BIT_LEVEL_SEL 4
`define RDC_BIT_DROPOUT 0
`define RDC_BIT_DROP_IRQ_EN 0
`define RDC_BIT_DROP_IRQ_PRIO 0
`define RDC_BIT_EVT_ENTERED 0
`define RDC_BIT_EVT_ENDED 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RDC_RST_REG_OFF 1'b0
`define RDC_RST_LEVEL_SEL 1'b1
`define RDC_RST_DROP_IRQ_EN 1'b0
`define RDC_RST_DROP_IRQ_PRIO 1'b0
`define RDC_RST_EVT 2'h0

`endif

// ### common/regulator_dropout_control_pkg.sv
/*
 * Types shared by the regulator dropout control block.
 * Assumes nothing of its surroundings beyond the constants header.
 */
package regulator_dropout_control_pkg;

    // ------------------------------------------------------------------
    // Regulator controls driven to the analog block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic regulator_off;
        logic output_level_select;
    } reg_ctrl_s;

    // ------------------------------------------------------------------
    // Sticky dropout events, bit order matches status and mask
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ended;
        logic entered;
    } drop_evt_s;

    // ------------------------------------------------------------------
    // Bus answer registered in the setup cycle
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } apb_rsp_s;

endpackage

// ### src/level_sync2.sv
/*
 * Two flip-flop synchroniser for slow levels.
 * Assumes the input changes far slower than the clock; only the second
 * stage may be read by other logic.
 */
`timescale 1ns/10ps
module level_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Level in and out
    input wire logic [WIDTH-1:0] level_async,
    output logic [WIDTH-1:0] level_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // Next values of both stages
    always_comb begin
        meta_d = level_async;
        sync_d = meta_q;
    end

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign level_sync = sync_q;

endmodule

// ### src/regulator_dropout_control.sv
/*
 * Register control around the core voltage regulator: enable, output
 * level select, dropout status, dropout interrupt request and priority,
 * plus sticky dropout events behind a mask on one interrupt line.
 * Assumes an APB master on pclk, and an analog dropout comparator level
 * that is asynchronous to pclk.
 */
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "regulator_dropout_control_consts.svh"

module regulator_dropout_control #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog regulator
    input wire logic dropout_raw,
    output regulator_dropout_control_pkg::reg_ctrl_s reg_ctrl,
    // Interrupt controller
    output logic dropout_irq_req,
    output logic dropout_irq_priority,
    output logic irq
);

    import regulator_dropout_control_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    // Word hit on a register index; misaligned addresses never hit
    function automatic logic idx_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0] idx
    );
        logic [ADDR_W-3:0] want;
        want = (ADDR_W-2)'(idx);
        return (addr[ADDR_W-1:2] == want) && (addr[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic drop_sync;
    logic drop_prev_q;
    logic drop_prev_d;
    reg_ctrl_s ctrl_q;
    reg_ctrl_s ctrl_d;
    logic irq_en_q;
    logic irq_en_d;
    logic irq_prio_q;
    logic irq_prio_d;
    drop_evt_s evt_q;
    drop_evt_s evt_d;
    drop_evt_s mask_q;
    drop_evt_s mask_d;
    drop_evt_s evt_set;
    drop_evt_s evt_clr;
    apb_rsp_s rsp_q;
    apb_rsp_s rsp_d;
    logic drop_req_q;
    logic drop_req_d;
    logic irq_q;
    logic irq_d;
    logic setup;
    logic wr_en;
    logic hit_ctrl;
    logic hit_en;
    logic hit_prio;
    logic hit_evt;
    logic hit_mask;
    logic hit_any;

    // ------------------------------------------------------------------
    // Dropout level crossing
    // ------------------------------------------------------------------

    // Comparator output is analog-timed, so it is retimed first
    level_sync2 #(
        .WIDTH(1)
    ) u_drop_sync (
        .pclk(pclk),
        .presetn(presetn),
        .level_async(dropout_raw),
        .level_sync(drop_sync)
    );

    // ------------------------------------------------------------------
    // Bus phase decode
    // ------------------------------------------------------------------

    // Writes land only at the edge that completes the access
    always_comb begin
        setup = psel && !penable;
        wr_en = psel && penable && pwrite && rsp_q.ready;
        hit_ctrl = idx_hit(paddr, `RDC_IDX_REG_CTRL);
        hit_en = idx_hit(paddr, `RDC_IDX_EXT_IRQ_EN2);
        hit_prio = idx_hit(paddr, `RDC_IDX_EXT_IRQ_PRIO2);
        hit_evt = idx_hit(paddr, `RDC_IDX_EVT_STATUS);
        hit_mask = idx_hit(paddr, `RDC_IDX_EVT_MASK);
        hit_any = hit_ctrl || hit_en || hit_prio || hit_evt || hit_mask;
    end

    // ------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------

    // Answer is built in setup so pready can come from a flop; the
    // price is one fixed wait state-free access of two cycles
    always_comb begin
        rsp_d = '0;
        if (setup) begin
            rsp_d.ready = 1'b1;
            rsp_d.slverr = !hit_any;
            if (!pwrite) begin
                if (hit_ctrl) begin
                    rsp_d.rdata[`RDC_BIT_REG_OFF] = ctrl_q.regulator_off;
                    rsp_d.rdata[`RDC_BIT_LEVEL_SEL] =
                        ctrl_q.output_level_select;
                    rsp_d.rdata[`RDC_BIT_DROPOUT] = drop_sync;
                end
                if (hit_en) begin
                    rsp_d.rdata[`RDC_BIT_DROP_IRQ_EN] = irq_en_q;
                end
                if (hit_prio) begin
                    rsp_d.rdata[`RDC_BIT_DROP_IRQ_PRIO] = irq_prio_q;
                end
                if (hit_evt) begin
                    rsp_d.rdata[1:0] = evt_q;
                end
                if (hit_mask) begin
                    rsp_d.rdata[1:0] = mask_q;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // ------------------------------------------------------------------
    // Regulator and interrupt configuration
    // ------------------------------------------------------------------

    // Bit 6 reads zero and is not stored; other bits are don't-care
    always_comb begin
        ctrl_d = ctrl_q;
        irq_en_d = irq_en_q;
        irq_prio_d = irq_prio_q;
        mask_d = mask_q;
        if (wr_en && hit_ctrl) begin
            ctrl_d.regulator_off = pwdata[`RDC_BIT_REG_OFF];
            ctrl_d.output_level_select =
                pwdata[`RDC_BIT_LEVEL_SEL];
        end
        if (wr_en && hit_en) begin
            // Software may drop this in service and restore it later
            irq_en_d = pwdata[`RDC_BIT_DROP_IRQ_EN];
        end
        if (wr_en && hit_prio) begin
            irq_prio_d = pwdata[`RDC_BIT_DROP_IRQ_PRIO];
        end
        if (wr_en && hit_mask) begin
            mask_d = pwdata[1:0];
        end
    end

    // Regulator comes up enabled at the upper level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q.regulator_off <= `RDC_RST_REG_OFF;
            ctrl_q.output_level_select <= `RDC_RST_LEVEL_SEL;
            irq_en_q <= `RDC_RST_DROP_IRQ_EN;
            irq_prio_q <= `RDC_RST_DROP_IRQ_PRIO;
            mask_q <= `RDC_RST_EVT;
        end else begin
            ctrl_q <= ctrl_d;
            irq_en_q <= irq_en_d;
            irq_prio_q <= irq_prio_d;
            mask_q <= mask_d;
        end
    end

    // ------------------------------------------------------------------
    // Dropout events and requests
    // ------------------------------------------------------------------

    // Edges of the retimed level; set beats a write-one clear
    always_comb begin
        drop_prev_d = drop_sync;
        evt_set.entered = drop_sync && !drop_prev_q;
        evt_set.ended = !drop_sync && drop_prev_q;
        evt_clr = '0;
        if (wr_en && hit_evt) begin
            evt_clr = pwdata[1:0];
        end
        evt_d = (evt_q & ~evt_clr) | evt_set;
        // Live request, nothing latched, so it ends with the dropout
        drop_req_d = drop_sync && irq_en_q;
        irq_d = |(evt_d & mask_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_prev_q <= 1'b0;
            evt_q <= `RDC_RST_EVT;
            drop_req_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            drop_prev_q <= drop_prev_d;
            evt_q <= evt_d;
            drop_req_q <= drop_req_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from a flop
    // ------------------------------------------------------------------
    assign prdata = rsp_q.rdata;
    assign pready = rsp_q.ready;
    assign pslverr = rsp_q.slverr;
    assign reg_ctrl = ctrl_q;
    assign dropout_irq_req = drop_req_q;
    assign dropout_irq_priority = irq_prio_q;
    assign irq = irq_q;

endmodule

// ### tb/regulator_dropout_control_props.sv
/*
 * Port checker for the regulator dropout control block.
 * Assumes the package and constants header are compiled first.
 */
`timescale 1ns/10ps
`include "regulator_dropout_control_consts.svh"
module regulator_dropout_control_props #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Regulator and interrupts
    input wire logic dropout_raw,
    input wire regulator_dropout_control_pkg::reg_ctrl_s reg_ctrl,
    input wire logic dropout_irq_req,
    input wire logic dropout_irq_priority,
    input wire logic irq
);
    import regulator_dropout_control_pkg::*;
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    localparam int CTRL_A = 4 * `RDC_IDX_REG_CTRL;
    localparam int EN_A = 4 * `RDC_IDX_EXT_IRQ_EN2;
    localparam int PRIO_A = 4 * `RDC_IDX_EXT_IRQ_PRIO2;
    logic wr_acc;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Completed write, the only moment a configuration register may change
    assign wr_acc = psel && penable && pready && pwrite;

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    a_req_needs_drop: assert property (
        dropout_irq_req |-> $past(dropout_raw, 3))
        else $error("dropout request without synced dropout");
    a_req_off_disable: assert property (
        wr_acc && paddr == ADDR_W'(EN_A) && !pwdata[0]
        |-> ##[1:3] !dropout_irq_req)
        else $error("dropout request survives disable");
    a_ctrl_write: assert property (
        wr_acc && paddr == ADDR_W'(CTRL_A) |-> ##2
        reg_ctrl == {$past(pwdata[7], 2), $past(pwdata[4], 2)})
        else $error("control outputs do not follow write");
    a_prio_write: assert property (
        wr_acc && paddr == ADDR_W'(PRIO_A) |-> ##2
        dropout_irq_priority == $past(pwdata[0], 2))
        else $error("priority output does not follow write");
endmodule
bind regulator_dropout_control regulator_dropout_control_props #(
    .ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dropout_raw(dropout_raw), .reg_ctrl(reg_ctrl),
    .dropout_irq_req(dropout_irq_req),
    .dropout_irq_priority(dropout_irq_priority), .irq(irq));

// ### tb/regulator_dropout_control_tb.sv
/*
 * Self-checking bench for the regulator dropout control block.
 * Assumes no wait states are needed, but waits on pready regardless.
 */
`timescale 1ns/10ps
`include "regulator_dropout_control_consts.svh"
module regulator_dropout_control_tb;
    import regulator_dropout_control_pkg::*;
    localparam logic [11:0] CTRL = 12'(4 * `RDC_IDX_REG_CTRL);
    localparam logic [11:0] EN = 12'(4 * `RDC_IDX_EXT_IRQ_EN2);
    localparam logic [11:0] PRIO = 12'(4 * `RDC_IDX_EXT_IRQ_PRIO2);
    localparam logic [11:0] STAT = 12'(4 * `RDC_IDX_EVT_STATUS);
    localparam logic [11:0] MASK = 12'(4 * `RDC_IDX_EVT_MASK);
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, dropout_raw = 0, dropout_irq_req;
    logic dropout_irq_priority, irq, errv;
    reg_ctrl_s reg_ctrl;
    int errors = 0, n_compared = 0;

    always #50 pclk = ~pclk;

    regulator_dropout_control uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dropout_raw(dropout_raw),
        .reg_ctrl(reg_ctrl), .dropout_irq_req(dropout_irq_req),
        .dropout_irq_priority(dropout_irq_priority), .irq(irq));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            errors++;
        end
    endtask

    // One APB transfer; read data and error taken at the pready edge.
    // No local limit: only the watchdog may end a wait for pready
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(logic [11:0] a, logic [31:0] exp, string name);
        apb(1'b0, a, 32'h0);
        chk(name, rdv, exp);
    endtask

    task automatic summarize;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk("reg_ctrl", 32'(reg_ctrl), 32'h1);
        rd(CTRL, 32'h10, "control");
        rd(EN, 32'h0, "irq enable");
        rd(MASK, 32'h0, "mask");
    endtask

    // Bit 6 is not stored and bit 0 is read-only
    task automatic t_ctrl;
        apb(1'b1, CTRL, 32'hFF);
        repeat (2) @(posedge pclk);
        chk("reg_ctrl", 32'(reg_ctrl), 32'h3);
        rd(CTRL, 32'h90, "control");
        apb(1'b1, CTRL, 32'h00);
        repeat (2) @(posedge pclk);
        chk("reg_ctrl", 32'(reg_ctrl), 32'h0);
        rd(CTRL, 32'h00, "control");
    endtask

    task automatic t_bad;
        apb(1'b1, 12'h338, 32'hFF);
        chk("slverr", 32'(errv), 32'h1);
        rd(12'h325, 32'h0, "misaligned");
        chk("slverr", 32'(errv), 32'h1);
        rd(MASK, 32'h0, "mask");
    endtask

    // Sticky events: masked, unmasked, cleared one by one
    task automatic t_events;
        dropout_raw <= 1'b1;
        repeat (4) @(posedge pclk);
        dropout_raw <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(STAT, 32'h3, "status");
        chk("irq masked", 32'(irq), 32'h0);
        apb(1'b1, MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq", 32'(irq), 32'h1);
        apb(1'b1, STAT, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq", 32'(irq), 32'h0);
        rd(STAT, 32'h2, "status");
        apb(1'b1, MASK, 32'h3);
        repeat (2) @(posedge pclk);
        chk("irq", 32'(irq), 32'h1);
        apb(1'b1, STAT, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq", 32'(irq), 32'h0);
        rd(STAT, 32'h0, "status");
    endtask

    // Service flow: disable in dropout, re-enable once bit 0 clears
    task automatic t_drop;
        apb(1'b1, EN, 32'h1);
        apb(1'b1, PRIO, 32'h1);
        repeat (2) @(posedge pclk);
        chk("priority", 32'(dropout_irq_priority), 32'h1);
        dropout_raw <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("req early", 32'(dropout_irq_req), 32'h0);
        @(posedge pclk);
        chk("req", 32'(dropout_irq_req), 32'h1);
        rd(CTRL, 32'h01, "dropout bit");
        apb(1'b1, EN, 32'h0);
        repeat (2) @(posedge pclk);
        chk("req off", 32'(dropout_irq_req), 32'h0);
        dropout_raw <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(CTRL, 32'h00, "dropout bit");
        apb(1'b1, EN, 32'h1);
        repeat (3) @(posedge pclk);
        chk("req pending", 32'(dropout_irq_req), 32'h0);
    endtask

    // Mid-run reset: regulator back on, priority and irq cleared
    task automatic t_rst;
        apb(1'b1, CTRL, 32'h80);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("reg_ctrl", 32'(reg_ctrl), 32'h1);
        chk("priority", 32'(dropout_irq_priority), 32'h0);
        chk("irq", 32'(irq), 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CTRL, 32'h10, "control");
        rd(STAT, 32'h0, "status");
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_ctrl();
        t_bad();
        t_events();
        t_drop();
        t_rst();
        summarize();
    end

    // Watchdog well beyond the hundred or so cycles the run needs
    initial begin
        #1000000;
        errors++;
        summarize();
    end
endmodule
